// ---- lstb_pkg.sv ----
`default_nettype none
package lstb_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_SLOT_CAPTURE = 32'h4000001c;
  localparam logic [31:0] ADDR_FINE_CAPTURE = 32'h40000020;
  localparam logic [31:0] ADDR_ADDR_LOW = 32'h40000024;
  localparam logic [31:0] ADDR_ADDR_HIGH = 32'h40000028;
  localparam logic [31:0] ADDR_POINTERS = 32'h4000002c;
  localparam logic [31:0] ADDR_SLEEP_CTRL = 32'h40000030;
  localparam logic [31:0] ADDR_SLEEP_TIME = 32'h40000034;
  localparam logic [31:0] ADDR_SLEEP_DUR = 32'h40000038;
  localparam logic [31:0] ADDR_WAKE_TIMING = 32'h4000003c;
  localparam logic [31:0] ADDR_SAMPLE_TRIG = 32'h40000068;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h40000070;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h40000074;
  localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h40000078;
  // field positions
  localparam int PRIVACY_BIT = 16;
  localparam int ETP_LSB = 16;
  localparam int EXT_DIS_BIT = 31;
  localparam int SLEEP_STAT_BIT = 15;
  localparam int SOFT_WAKE_BIT = 4;
  localparam int CORR_EN_BIT = 3;
  localparam int SLEEP_ON_BIT = 2;
  localparam int EXT_DELAY_LSB = 21;
  localparam int ASSERT_LEAD_LSB = 10;
  // interrupt status bit positions
  localparam int EVT_SLOT = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_WAKE = 2;
  localparam int EVT_W = 3;
  // value of the wake interrupt enable field that allows the interrupt
  localparam logic [1:0] WAKE_IRQ_ON = 2'h3;
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int SLOT_US = 625;
  // sleep sequencer states
  typedef enum logic [0:0] {LSTB_ACTIVE, LSTB_SLEEP} lstb_state_e;
endpackage
`default_nettype wire

// ---- lstb_top.sv ----
`default_nettype none
module lstb_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pins from outside the clock domain
  input wire logic low_power_clk_i,
  input wire logic ext_wake_i,
  // link-layer side outputs
  output logic [15:0] exchange_table_pointer_o,
  output logic [14:0] receive_descriptor_pointer_o,
  output logic sleep_clock_mux_o,
  output logic low_power_wake_interrupt_o,
  output logic irq_o
);

  // reset release synchroniser
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin synchronisers; the first stage is read only by the second
  logic lp_meta;
  logic lp_sync;
  logic lp_prev;
  logic ext_meta;
  logic ext_sync;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lp_meta <= 1'b0;
      lp_sync <= 1'b0;
      lp_prev <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      lp_meta <= low_power_clk_i;
      lp_sync <= lp_meta;
      lp_prev <= lp_sync;
      ext_meta <= ext_wake_i;
      ext_sync <= ext_meta;
    end
  end

  // one-cycle enable per low-power clock rising edge; the low-power clock
  // must be well under half the system rate or edges are missed
  wire lp_tick = lp_sync & ~lp_prev;

  // software-visible state
  logic [26:0] slot_count_capture; // captured slot count
  logic [9:0] fine_count_capture; // captured microsecond count
  // device address words and privacy flag, plain storage
  logic [31:0] address_low_bits;
  logic [15:0] address_high_bits;
  logic privacy_flag;
  // sleep control fields; the action bits clear themselves
  logic external_wake_disable;
  logic software_wake_request;
  logic sleep_request;
  logic [1:0] wake_irq_enable;
  // sleep length and elapsed count, both in low-power cycles
  logic [31:0] sleep_length;
  logic [31:0] sleep_elapsed;
  // wake interrupt timing fields, all in low-power cycles
  logic [10:0] external_wake_release_delay;
  logic [10:0] wake_assert_lead;
  logic [9:0] wake_release_lead;
  // sticky event status and its enable mask
  logic [lstb_pkg::EVT_W-1:0] irq_status;
  logic [lstb_pkg::EVT_W-1:0] irq_enable;

  // running timebase
  logic [6:0] us_div; // system cycles within one microsecond
  logic [9:0] microsecond_count_value;
  logic [26:0] slot_count_value;
  logic counters_on; // counters stop in sleep until correction is requested

  // sleep sequencer state
  lstb_pkg::lstb_state_e state;
  logic [31:0] remaining; // low-power cycles left before expiry
  logic [10:0] ext_release_cnt; // low-power cycles until irq release

  // address decode
  // full 32-bit compare, so aliases of the map read as zero
  wire hit_slot = (addr_i == lstb_pkg::ADDR_SLOT_CAPTURE);
  wire hit_fine = (addr_i == lstb_pkg::ADDR_FINE_CAPTURE);
  wire hit_low = (addr_i == lstb_pkg::ADDR_ADDR_LOW);
  wire hit_high = (addr_i == lstb_pkg::ADDR_ADDR_HIGH);
  wire hit_ptr = (addr_i == lstb_pkg::ADDR_POINTERS);
  wire hit_ctrl = (addr_i == lstb_pkg::ADDR_SLEEP_CTRL);
  wire hit_time = (addr_i == lstb_pkg::ADDR_SLEEP_TIME);
  wire hit_dur = (addr_i == lstb_pkg::ADDR_SLEEP_DUR);
  wire hit_wtim = (addr_i == lstb_pkg::ADDR_WAKE_TIMING);
  wire hit_trig = (addr_i == lstb_pkg::ADDR_SAMPLE_TRIG);
  wire hit_ist = (addr_i == lstb_pkg::ADDR_IRQ_STATUS);
  wire hit_ien = (addr_i == lstb_pkg::ADDR_IRQ_ENABLE);
  wire hit_icl = (addr_i == lstb_pkg::ADDR_IRQ_CLEAR);

  // write strobes per register
  // control action bits act only on a write of one; a zero does nothing, but any write fires the sample trigger
  wire wr_ctrl = wr_i & hit_ctrl;
  wire sample_clock_trigger = wr_i & hit_trig;
  wire corr_write = wr_ctrl & wdata_i[lstb_pkg::CORR_EN_BIT];
  wire soft_wake_write = wr_ctrl & wdata_i[lstb_pkg::SOFT_WAKE_BIT];
  wire sleep_on_write = wr_ctrl & wdata_i[lstb_pkg::SLEEP_ON_BIT];

  // microsecond and slot wraps
  // the divider stands still while the counters are stopped
  wire us_tick = counters_on && (us_div == 7'(lstb_pkg::US_CYCLES - 1));
  wire slot_wrap = us_tick && (microsecond_count_value == 10'(lstb_pkg::SLOT_US - 1));

  // sleep sequencer decisions
  wire asleep = (state == lstb_pkg::LSTB_SLEEP);
  wire ext_wake_ok = ext_sync & ~external_wake_disable;
  wire [31:0] remaining_dec = remaining - 32'h1;
  // expiry at one remaining cycle, so a length of zero wakes on the first edge
  wire timer_expire = asleep && lp_tick && (remaining <= 32'h1);
  wire wake_now = asleep && (timer_expire || software_wake_request || ext_wake_ok);
  wire sleep_enter = !asleep && sleep_request;
  wire irq_gate = (wake_irq_enable == lstb_pkg::WAKE_IRQ_ON);
  // leads compare against the count left after this edge's decrement
  wire hit_assert = asleep && lp_tick && (remaining_dec == {21'h0, wake_assert_lead});
  wire hit_release = asleep && lp_tick && (remaining_dec == {22'h0, wake_release_lead});
  // an external wake only marks the irq when no other cause wins
  wire ext_wake_event = asleep && ext_wake_ok && !timer_expire && !software_wake_request;
  // release after an external wake only counts once the core is awake
  wire ext_release = !asleep && lp_tick && (ext_release_cnt == 11'h1);

  // event sources for the interrupt status
  // bit order must match the status positions in the package
  wire [lstb_pkg::EVT_W-1:0] events = {wake_now, sleep_enter, slot_wrap};

  // microsecond divider and fine / slot counters
  // the fine count restarts each slot; the slot count wraps at 27 bits
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      us_div <= 7'h0;
      microsecond_count_value <= 10'h0;
      slot_count_value <= 27'h0;
    end else if (counters_on) begin
      us_div <= us_tick ? 7'h0 : us_div + 7'h1;
      if (slot_wrap) begin
        microsecond_count_value <= 10'h0;
        slot_count_value <= slot_count_value + 27'h1;
      end else if (us_tick) begin
        microsecond_count_value <= microsecond_count_value + 10'h1;
      end
    end
  end

  // capture of the running counters for software
  // both captures share one strobe so software sees a consistent pair
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_count_capture <= 27'h0;
      fine_count_capture <= 10'h0;
    end else if (sample_clock_trigger) begin
      slot_count_capture <= slot_count_value;
      fine_count_capture <= microsecond_count_value;
    end
  end

  // plain read/write configuration registers
  // writes take effect at the edge that samples the strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      address_low_bits <= 32'h0;
      address_high_bits <= 16'h0;
      privacy_flag <= 1'b0;
      exchange_table_pointer_o <= 16'h0;
      receive_descriptor_pointer_o <= 15'h0;
      sleep_length <= 32'h0;
      external_wake_release_delay <= 11'h0;
      wake_assert_lead <= 11'h0;
      wake_release_lead <= 10'h0;
      external_wake_disable <= 1'b0;
      wake_irq_enable <= 2'h0;
      irq_enable <= '0;
    end else if (wr_i) begin
      if (hit_low) begin
        address_low_bits <= wdata_i;
      end
      if (hit_high) begin
        address_high_bits <= wdata_i[15:0];
        privacy_flag <= wdata_i[lstb_pkg::PRIVACY_BIT];
      end
      if (hit_ptr) begin
        exchange_table_pointer_o <= wdata_i[31:16];
        receive_descriptor_pointer_o <= wdata_i[14:0];
      end
      if (hit_time) begin
        sleep_length <= wdata_i;
      end
      if (hit_wtim) begin
        external_wake_release_delay <= wdata_i[31:21];
        wake_assert_lead <= wdata_i[20:10];
        wake_release_lead <= wdata_i[9:0];
      end
      if (hit_ctrl) begin
        external_wake_disable <= wdata_i[lstb_pkg::EXT_DIS_BIT];
        wake_irq_enable <= wdata_i[1:0];
      end
      if (hit_ien) begin
        irq_enable <= wdata_i[lstb_pkg::EVT_W-1:0];
      end
    end
  end

  // self-clearing control bits; a write of one in the clearing cycle wins
  // a wake request written while awake stays pending until the next sleep
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      software_wake_request <= 1'b0;
      sleep_request <= 1'b0;
    end else begin
      if (soft_wake_write) begin
        software_wake_request <= 1'b1;
      end else if (wake_now) begin
        software_wake_request <= 1'b0;
      end
      if (sleep_on_write) begin
        sleep_request <= 1'b1;
      end else if (wake_now) begin
        sleep_request <= 1'b0;
      end
    end
  end

  // counters stay stopped after wake until correction is requested
  // correction writes during sleep are ignored, so restart happens awake only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      counters_on <= 1'b1;
    end else if (sleep_enter) begin
      counters_on <= 1'b0;
    end else if (corr_write && !asleep) begin
      counters_on <= 1'b1;
    end
  end

  // sleep sequencer
  // elapsed count is cleared on entry and frozen on wake for software
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= lstb_pkg::LSTB_ACTIVE;
      remaining <= 32'h0;
      sleep_elapsed <= 32'h0;
      sleep_clock_mux_o <= 1'b0;
    end else begin
      case (state)
        lstb_pkg::LSTB_ACTIVE: begin
          if (sleep_enter) begin
            state <= lstb_pkg::LSTB_SLEEP;
            remaining <= sleep_length;
            sleep_elapsed <= 32'h0;
            sleep_clock_mux_o <= 1'b1;
          end
        end
        lstb_pkg::LSTB_SLEEP: begin
          // the expiry edge still counts as an elapsed cycle
          if (lp_tick) begin
            sleep_elapsed <= sleep_elapsed + 32'h1;
            remaining <= remaining_dec;
          end
          if (wake_now) begin
            state <= lstb_pkg::LSTB_ACTIVE;
            sleep_clock_mux_o <= 1'b0;
          end
        end
        default: begin
          state <= lstb_pkg::LSTB_ACTIVE;
          sleep_clock_mux_o <= 1'b0;
        end
      endcase
    end
  end

  // low-power wake interrupt: timed set/release near expiry, delayed
  // release after an external wake
  // an external set outranks the timed release and set in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      low_power_wake_interrupt_o <= 1'b0;
      ext_release_cnt <= 11'h0;
    end else begin
      if (ext_wake_event && irq_gate) begin
        low_power_wake_interrupt_o <= 1'b1;
        ext_release_cnt <= external_wake_release_delay;
      end else if (hit_release) begin
        low_power_wake_interrupt_o <= 1'b0;
      end else if (hit_assert && irq_gate) begin
        low_power_wake_interrupt_o <= 1'b1;
      end else if (ext_release) begin
        low_power_wake_interrupt_o <= 1'b0;
        ext_release_cnt <= 11'h0;
      end else if (!asleep && lp_tick && ext_release_cnt != 11'h0) begin
        ext_release_cnt <= ext_release_cnt - 11'h1;
      end
    end
  end

  // sticky interrupt status; a new event wins over a clear
  // irq_o is built from the next status value, one cycle behind the event
  wire [lstb_pkg::EVT_W-1:0] irq_clear = (wr_i && hit_icl) ? wdata_i[lstb_pkg::EVT_W-1:0] : '0;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | events;
      irq_o <= |(((irq_status & ~irq_clear) | events) & irq_enable);
    end
  end

  // read selection
  // write-only and unmapped addresses read as zero
  wire [31:0] ctrl_word = {external_wake_disable, 15'h0, sleep_clock_mux_o, 10'h0,
                           software_wake_request, 2'h0, wake_irq_enable};
  wire [31:0] rd_mux =
    hit_slot ? {5'h0, slot_count_capture} :
    hit_fine ? {22'h0, fine_count_capture} :
    hit_low  ? address_low_bits :
    hit_high ? {15'h0, privacy_flag, address_high_bits} :
    hit_ptr  ? {exchange_table_pointer_o, 1'b0, receive_descriptor_pointer_o} :
    hit_ctrl ? ctrl_word :
    hit_time ? sleep_length :
    hit_dur  ? sleep_elapsed :
    hit_wtim ? {external_wake_release_delay, wake_assert_lead, wake_release_lead} :
    hit_ist  ? {29'h0, irq_status} :
    hit_ien  ? {29'h0, irq_enable} :
    lstb_pkg::RESET_WORD;

  // read data registered, valid the cycle after the strobe only
  // zero outside read cycles keeps a shared read bus quiet
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0;
    end
  end

endmodule
`default_nettype wire

// ---- lstb_properties.sv ----
`default_nettype none
module lstb_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // link-layer side
  input wire logic [15:0] exchange_table_pointer_o,
  input wire logic [14:0] receive_descriptor_pointer_o,
  input wire logic sleep_clock_mux_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // decoded accesses
  wire logic wr_ctrl = wr_i && addr_i == lstb_pkg::ADDR_SLEEP_CTRL;
  wire logic rd_ctrl = rd_i && addr_i == lstb_pkg::ADDR_SLEEP_CTRL;
  wire logic wr_ptr = wr_i && addr_i == lstb_pkg::ADDR_POINTERS;
  wire logic sleep_wr = wr_ctrl && wdata_i[2];
  logic [31:0] low_q; // shadow of the address low word
  logic [16:0] high_q; // shadow of the high bits and flag
  // shadows follow software writes so readback can be judged
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_q <= 32'h0;
      high_q <= 17'h0;
    end else if (wr_i && addr_i == lstb_pkg::ADDR_ADDR_LOW) begin
      low_q <= wdata_i;
    end else if (wr_i && addr_i == lstb_pkg::ADDR_ADDR_HIGH) begin
      high_q <= wdata_i[16:0];
    end
  end
  addr_low_a: assert property (rd_i && addr_i == lstb_pkg::ADDR_ADDR_LOW |=> rdata_o == low_q)
    else $error("address low readback wrong");
  addr_high_a: assert property (rd_i && addr_i == lstb_pkg::ADDR_ADDR_HIGH |=> rdata_o == {15'h0, high_q})
    else $error("address high readback wrong");
  table_pointer_a: assert property (wr_ptr |=> exchange_table_pointer_o == $past(wdata_i[31:16]))
    else $error("table pointer not taken");
  rx_pointer_a: assert property (wr_ptr |=> receive_descriptor_pointer_o == $past(wdata_i[14:0]))
    else $error("receive pointer not taken");
  sleep_entry_a: assert property (sleep_wr && !sleep_clock_mux_o |-> ##2 sleep_clock_mux_o)
    else $error("sleep request not obeyed");
  sleep_cause_a: assert property ($rose(sleep_clock_mux_o) |-> $past(sleep_wr, 2))
    else $error("sleep entered without request");
  soft_wake_a: assert property (wr_ctrl && wdata_i[4] && sleep_clock_mux_o |-> ##[1:4] !sleep_clock_mux_o)
    else $error("software wake ignored");
  status_bit_a: assert property (rd_ctrl |=> rdata_o[15] == $past(sleep_clock_mux_o))
    else $error("sleep status bit wrong");
  self_clear_a: assert property (rd_ctrl |=> rdata_o[3:2] == 2'h0)
    else $error("control action bits read nonzero");
  // main scenarios
  cover property ($rose(sleep_clock_mux_o));
  cover property ($fell(sleep_clock_mux_o));
  cover property (wr_ptr ##2 (rd_i && addr_i == lstb_pkg::ADDR_POINTERS));
endmodule
bind lstb_top lstb_checker chk (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .exchange_table_pointer_o, .receive_descriptor_pointer_o, .sleep_clock_mux_o);
`default_nettype wire

// ---- lstb_top_tb.sv ----
`default_nettype none
module lstb_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, all defined at time zero
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic low_power_clk_i = 1'b0;
  logic ext_wake_i = 1'b0;
  // observed outputs
  logic [31:0] rdata_o;
  logic [15:0] exchange_table_pointer_o;
  logic [14:0] receive_descriptor_pointer_o;
  logic sleep_clock_mux_o;
  logic low_power_wake_interrupt_o;
  logic irq_o;
  int fails = 0;
  int n_compared = 0;
  lstb_top uut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .low_power_clk_i, .ext_wake_i,
    .exchange_table_pointer_o, .receive_descriptor_pointer_o, .sleep_clock_mux_o,
    .low_power_wake_interrupt_o, .irq_o);
  // 100 MHz system clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // low-power ticks, slow enough for the two-stage synchroniser
  task automatic lp(input int n);
    @(posedge clk_i);
    repeat (n) begin
      low_power_clk_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      low_power_clk_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    #1;
  endtask
  // hang guard: counts as a mismatch
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  initial begin
    logic [31:0] s1, f1, s2, f2, d;
    static logic [31:0] regs[9] = '{lstb_pkg::ADDR_SLOT_CAPTURE, lstb_pkg::ADDR_FINE_CAPTURE, lstb_pkg::ADDR_ADDR_LOW,
      lstb_pkg::ADDR_ADDR_HIGH, lstb_pkg::ADDR_POINTERS, lstb_pkg::ADDR_SLEEP_CTRL, lstb_pkg::ADDR_SLEEP_TIME,
      lstb_pkg::ADDR_SLEEP_DUR, lstb_pkg::ADDR_WAKE_TIMING};
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (regs[i]) rdc(regs[i], 32'h0);
    wr(lstb_pkg::ADDR_ADDR_LOW, 32'ha5a5c3c3);
    rdc(lstb_pkg::ADDR_ADDR_LOW, 32'ha5a5c3c3);
    wr(lstb_pkg::ADDR_ADDR_HIGH, 32'hffffffff);
    rdc(lstb_pkg::ADDR_ADDR_HIGH, 32'h0001ffff);
    wr(lstb_pkg::ADDR_POINTERS, 32'hffffffff);
    rdc(lstb_pkg::ADDR_POINTERS, 32'hffff7fff);
    chk({exchange_table_pointer_o, 1'b0, receive_descriptor_pointer_o}, 32'hffff7fff);
    rdc(32'h40000064, 32'h0);
    // two captures exactly 1000 cycles (10 us) apart
    wr(lstb_pkg::ADDR_SAMPLE_TRIG, 32'h0);
    rd(lstb_pkg::ADDR_SLOT_CAPTURE, s1);
    rd(lstb_pkg::ADDR_FINE_CAPTURE, f1);
    repeat (994) @(posedge clk_i);
    wr(lstb_pkg::ADDR_SAMPLE_TRIG, 32'h1);
    rd(lstb_pkg::ADDR_SLOT_CAPTURE, s2);
    rd(lstb_pkg::ADDR_FINE_CAPTURE, f2);
    chk(f2, (f1 + 32'd10) % 32'd625);
    chk(s2, s1 + 32'((f1 + 32'd10) >= 32'd625));
    wr(lstb_pkg::ADDR_SLOT_CAPTURE, 32'hffffffff);
    rdc(lstb_pkg::ADDR_SLOT_CAPTURE, s2);
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h8000000b);
    rdc(lstb_pkg::ADDR_SLEEP_CTRL, 32'h80000003);
    // timed sleep: length 20, set lead 5, release lead 1, external delay 3
    wr(lstb_pkg::ADDR_SLEEP_TIME, 32'd20);
    rdc(lstb_pkg::ADDR_SLEEP_TIME, 32'd20);
    wr(lstb_pkg::ADDR_WAKE_TIMING, 32'h00601401);
    rdc(lstb_pkg::ADDR_WAKE_TIMING, 32'h00601401);
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h00000007);
    rdc(lstb_pkg::ADDR_SLEEP_CTRL, 32'h00008003);
    rdc(lstb_pkg::ADDR_SLEEP_DUR, 32'h0);
    for (int k = 1; k <= 20; k++) begin
      lp(1);
      chk(low_power_wake_interrupt_o, 32'(k >= 15 && k < 19));
      chk(sleep_clock_mux_o, 32'(k < 20));
    end
    rdc(lstb_pkg::ADDR_SLEEP_DUR, 32'd20);
    rdc(lstb_pkg::ADDR_SLEEP_CTRL, 32'h00000003);
    // external wake blocked, then software wake
    wr(lstb_pkg::ADDR_SLEEP_TIME, 32'd1000);
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h80000007);
    ext_wake_i <= 1'b1;
    lp(2);
    chk(sleep_clock_mux_o, 1'b1);
    rdc(lstb_pkg::ADDR_SLEEP_DUR, 32'd2);
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h80000013);
    ext_wake_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk(sleep_clock_mux_o, 1'b0);
    rdc(lstb_pkg::ADDR_SLEEP_CTRL, 32'h80000003);
    // external wake allowed
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h00000007);
    lp(1);
    ext_wake_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1 chk(sleep_clock_mux_o, 1'b0);
    chk(low_power_wake_interrupt_o, 1'b1);
    ext_wake_i <= 1'b0;
    lp(2);
    chk(low_power_wake_interrupt_o, 1'b1);
    lp(2);
    chk(low_power_wake_interrupt_o, 1'b0);
    // sticky events, mask and clear
    wr(lstb_pkg::ADDR_IRQ_ENABLE, 32'h0);
    rd(lstb_pkg::ADDR_IRQ_STATUS, d);
    chk(d & 32'h6, 32'h6);
    chk(irq_o, 1'b0);
    wr(lstb_pkg::ADDR_IRQ_ENABLE, 32'h4);
    repeat (2) @(posedge clk_i);
    #1 chk(irq_o, 1'b1);
    wr(lstb_pkg::ADDR_IRQ_CLEAR, 32'h6);
    rd(lstb_pkg::ADDR_IRQ_STATUS, d);
    chk(d & 32'h6, 32'h0);
    chk(irq_o, 1'b0);
    // counters halt after wake until correction is enabled
    wr(lstb_pkg::ADDR_SAMPLE_TRIG, 32'h0);
    rd(lstb_pkg::ADDR_FINE_CAPTURE, f1);
    repeat (300) @(posedge clk_i);
    wr(lstb_pkg::ADDR_SAMPLE_TRIG, 32'h0);
    rdc(lstb_pkg::ADDR_FINE_CAPTURE, f1);
    wr(lstb_pkg::ADDR_SLEEP_CTRL, 32'h00000008);
    repeat (300) @(posedge clk_i);
    wr(lstb_pkg::ADDR_SAMPLE_TRIG, 32'h0);
    rd(lstb_pkg::ADDR_FINE_CAPTURE, f2);
    chk(32'((f2 - f1) >= 32'd3 && (f2 - f1) <= 32'd4), 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
